// file: rtl/osr_pkg.sv
// Shared constants and types for the orientation sensor serial register port
`default_nettype none

package osr_pkg;

  // ----------------------------------------------------------------
  // Bus identity and byte framing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR         = 7'h15;  // 0010101 binary
  localparam logic [3:0] BYTE_BITS          = 4'h8;
  localparam logic [5:0] PART_IDENT_DEFAULT = 6'h2a;  // Arbitrary value
  localparam int         FIFO_DEPTH_DEFAULT = 8;

  // ----------------------------------------------------------------
  // Register numbers, reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_X_ACCEL        = 8'h00;
  localparam logic [7:0] REG_Y_ACCEL        = 8'h01;
  localparam logic [7:0] REG_STATUS         = 8'h02;
  localparam logic [7:0] REG_DETECT         = 8'h04;
  localparam logic [7:0] REG_IDENT          = 8'h08;
  localparam logic [7:0] X_ACCEL_RESET      = 8'h00;
  localparam logic [7:0] Y_ACCEL_RESET      = 8'h00;
  localparam logic [6:0] STATUS_RESET       = 7'h00;
  localparam logic [7:0] DETECT_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;
  localparam int         INT_BIT            = 7;
  localparam int         POWER_DOWN_BIT     = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h3,
    ST_SEND = 3'h2,
    ST_MACK = 3'h6
  } osr_state_type;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'h0,
    KIND_PTR  = 2'h1,
    KIND_DATA = 2'h3
  } osr_kind_type;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } osr_wr_type;

endpackage : osr_pkg

`default_nettype wire

// file: rtl/osr_i2c_slave.sv
// Serial slave register port with write FIFO for a two-axis orientation sensor
`default_nettype none
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Write FIFO
// ------------------------------------------------------------------
module osr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrIdx_q;
  logic [AW-1:0]    rdIdx_q;
  logic [AW:0]      count_q;
  logic             doPush;
  logic             doPop;

  // Honest flags straight from the occupancy count
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdIdx_q];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // One storage entry per slot
  for (genvar e = 0; e < DEPTH; e++) begin : gEntry
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        mem_q[e] <= '0;
      end else if (clkEn && doPush && (wrIdx_q == AW'(e))) begin
        mem_q[e] <= inData;
      end
    end
  end

  // Index and count bookkeeping
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= '0;
    end else if (clkEn) begin
      if (doPush) begin
        wrIdx_q <= (wrIdx_q == AW'(DEPTH - 1)) ? '0 : wrIdx_q + 1'b1;
      end
      if (doPop) begin
        rdIdx_q <= (rdIdx_q == AW'(DEPTH - 1)) ? '0 : rdIdx_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : osr_fifo

// ------------------------------------------------------------------
// Serial slave and register file
// ------------------------------------------------------------------
module osr_i2c_slave #(
  parameter int         FIFO_DEPTH     = osr_pkg::FIFO_DEPTH_DEFAULT,
  parameter logic [5:0] PART_IDENT_LOW = osr_pkg::PART_IDENT_DEFAULT  // Arbitrary value
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [7:0] xAccelIn,
  input  wire logic [7:0] yAccelIn,
  input  wire logic [6:0] statusIn,
  input  wire logic       sampleValid,
  input  wire logic       eventSet,
  input  wire logic       cfgReady,
  output logic      [7:0] detectCfg,
  output logic            powerDown,
  output logic            intPin
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  osr_pkg::osr_state_type state_q, state_d;
  osr_pkg::osr_kind_type  kind_q, kind_d;
  logic       sclMeta_q, sclSync_q, sclPrev_q;
  logic       sdaMeta_q, sdaSync_q, sdaPrev_q;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic       readMode_q, readMode_d;
  logic       sdaOe_q, sdaOe_d;
  logic       mAck_q, mAck_d;
  logic [7:0] xAccel_q, yAccel_q;
  logic [6:0] status_q;
  logic       intFlag_q;
  logic [7:0] detectCfg_q;
  logic       powerDown_q;
  logic       sclRise, sclFall, startDet, stopDet;
  logic       byteDone, ackByte, addrMatch, loadSend, push, statusRead;
  logic [7:0] readByte;
  logic       fifoInReady, fifoOutValid;
  osr_pkg::osr_wr_type pushEntry, popEntry;

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  // Both lines idle high, so the flops reset high to avoid a false event
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclMeta_q <= sclIn;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  // Line events; both lines share latency so START and STOP stay aligned
  assign sclRise  = sclSync_q && !sclPrev_q;
  assign sclFall  = !sclSync_q && sclPrev_q;
  assign startDet = sclSync_q && sclPrev_q && sdaPrev_q && !sdaSync_q;
  assign stopDet  = sclSync_q && sclPrev_q && !sdaPrev_q && sdaSync_q;

  // ----------------------------------------------------------------
  // Byte decoding and read selection
  // ----------------------------------------------------------------
  assign byteDone  = sclFall && (bitCnt_q == osr_pkg::BYTE_BITS);
  assign addrMatch = (shift_q[7:1] == osr_pkg::SLAVE_ADDR);
  // A full FIFO refuses the byte, so the master sees no acknowledge
  assign ackByte   = (kind_q == osr_pkg::KIND_ADDR) ? addrMatch :
                     (kind_q == osr_pkg::KIND_DATA) ? fifoInReady : 1'b1;
  assign readByte  =
    (ptr_q == osr_pkg::REG_X_ACCEL) ? xAccel_q :
    (ptr_q == osr_pkg::REG_Y_ACCEL) ? yAccel_q :
    (ptr_q == osr_pkg::REG_STATUS)  ? {intFlag_q, status_q} :
    (ptr_q == osr_pkg::REG_IDENT)   ? {2'h0, PART_IDENT_LOW} :
                                      osr_pkg::UNMAPPED_READ;
  assign pushEntry = '{ptr: ptr_q, data: shift_q};

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  // STOP and START override every state, so a repeated START restarts cleanly
  always_comb begin
    state_d    = state_q;
    kind_d     = kind_q;
    bitCnt_d   = bitCnt_q;
    shift_d    = shift_q;
    ptr_d      = ptr_q;
    readMode_d = readMode_q;
    sdaOe_d    = sdaOe_q;
    mAck_d     = mAck_q;
    push       = 1'b0;
    loadSend   = 1'b0;
    if (stopDet) begin
      state_d = osr_pkg::ST_IDLE;
      sdaOe_d = 1'b0;
    end else if (startDet) begin
      state_d  = osr_pkg::ST_RECV;
      kind_d   = osr_pkg::KIND_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d  = 1'b0;
    end else begin
      unique case (state_q)
        osr_pkg::ST_IDLE: begin
          sdaOe_d = 1'b0;
        end
        osr_pkg::ST_RECV: begin
          if (sclRise && (bitCnt_q != osr_pkg::BYTE_BITS)) begin
            shift_d  = {shift_q[6:0], sdaSync_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            state_d = ackByte ? osr_pkg::ST_ACK : osr_pkg::ST_IDLE;
            sdaOe_d = ackByte;
            if (kind_q == osr_pkg::KIND_ADDR) begin
              readMode_d = shift_q[0];
            end else if (kind_q == osr_pkg::KIND_PTR) begin
              ptr_d = shift_q;
            end else if (ackByte) begin
              push  = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        osr_pkg::ST_ACK: begin
          if (sclFall) begin
            if ((kind_q == osr_pkg::KIND_ADDR) && readMode_q) begin
              loadSend = 1'b1;
            end else begin
              state_d  = osr_pkg::ST_RECV;
              kind_d   = (kind_q == osr_pkg::KIND_ADDR) ? osr_pkg::KIND_PTR
                                                        : osr_pkg::KIND_DATA;
              bitCnt_d = 4'h0;
              sdaOe_d  = 1'b0;
            end
          end
        end
        osr_pkg::ST_SEND: begin
          if (byteDone) begin
            state_d = osr_pkg::ST_MACK;
            sdaOe_d = 1'b0;
          end else if (sclFall) begin
            sdaOe_d  = !shift_q[6];
            shift_d  = {shift_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + 4'h1;
          end
        end
        osr_pkg::ST_MACK: begin
          if (sclRise) begin
            mAck_d = !sdaSync_q;
          end else if (sclFall) begin
            if (mAck_q) begin
              loadSend = 1'b1;
            end else begin
              state_d = osr_pkg::ST_IDLE;
              sdaOe_d = 1'b0;
            end
          end
        end
        default: begin
          state_d = osr_pkg::ST_IDLE;
          sdaOe_d = 1'b0;
        end
      endcase
    end
    // Shared byte load for the first and every following read byte
    if (loadSend) begin
      state_d  = osr_pkg::ST_SEND;
      shift_d  = readByte;
      sdaOe_d  = !readByte[7];
      bitCnt_d = 4'h1;
      ptr_d    = ptr_q + 8'h01;
      mAck_d   = 1'b0;
    end
  end

  assign statusRead = loadSend && (ptr_q == osr_pkg::REG_STATUS);

  // State registers of the transfer engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= osr_pkg::ST_IDLE;
      kind_q     <= osr_pkg::KIND_ADDR;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      readMode_q <= 1'b0;
      sdaOe_q    <= 1'b0;
      mAck_q     <= 1'b0;
    end else if (clkEn) begin
      state_q    <= state_d;
      kind_q     <= kind_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      ptr_q      <= ptr_d;
      readMode_q <= readMode_d;
      sdaOe_q    <= sdaOe_d;
      mAck_q     <= mAck_d;
    end
  end

  // ----------------------------------------------------------------
  // Write path and register file
  // ----------------------------------------------------------------
  // Writes queue here so a busy sensor core throttles the master via NACK
  osr_fifo #(
    .WIDTH ($bits(osr_pkg::osr_wr_type)),
    .DEPTH (FIFO_DEPTH)
  ) uWriteFifo (
    .clock    (clock),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (pushEntry),
    .outValid (fifoOutValid),
    .outReady (cfgReady),
    .outData  (popEntry)
  );

  // Only the detection register takes writes; others drop silently
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      detectCfg_q <= osr_pkg::DETECT_RESET;
      powerDown_q <= 1'b0;
    end else if (clkEn && fifoOutValid && cfgReady &&
                 (popEntry.ptr == osr_pkg::REG_DETECT)) begin
      detectCfg_q <= popEntry.data;
      powerDown_q <= popEntry.data[osr_pkg::POWER_DOWN_BIT];
    end
  end

  // Sensor samples are frozen while powered down
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xAccel_q <= osr_pkg::X_ACCEL_RESET;
      yAccel_q <= osr_pkg::Y_ACCEL_RESET;
      status_q <= osr_pkg::STATUS_RESET;
    end else if (clkEn && sampleValid && !powerDown_q) begin
      xAccel_q <= xAccelIn;
      yAccel_q <= yAccelIn;
      status_q <= statusIn;
    end
  end

  // Interrupt flag: while powered up, a new event wins over a clearing read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intFlag_q <= 1'b0;
    end else if (clkEn) begin
      if (eventSet && !powerDown_q) begin
        intFlag_q <= 1'b1;
      end else if (statusRead) begin
        intFlag_q <= 1'b0;
      end
    end
  end

  // Pin outputs; the data line is only ever pulled low
  assign sdaOut    = 1'b0;
  assign sdaOe     = sdaOe_q;
  assign detectCfg = detectCfg_q;
  assign powerDown = powerDown_q;
  assign intPin    = intFlag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cbMain @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence seqAddrByteEnd;
    clkEn && !stopDet && !startDet && (state_q == osr_pkg::ST_RECV) &&
    byteDone && (kind_q == osr_pkg::KIND_ADDR);
  endsequence

  sequence seqMasterNack;
    clkEn && !stopDet && !startDet && (state_q == osr_pkg::ST_MACK) &&
    sclFall && !mAck_q;
  endsequence

  AST_DRIVE_ONLY_WHEN_OWNED: assert property (
    sdaOe_q |-> (state_q inside {osr_pkg::ST_ACK, osr_pkg::ST_SEND}))
    else $error("data line driven outside acknowledge or send");

  AST_CHANGE_CLOCK_LOW: assert property (
    $changed(sdaOe_q) && !$past(stopDet) && !$past(startDet) |-> !$past(sclSync_q))
    else $error("data line changed while clock high");

  AST_START_RESTARTS: assert property (
    clkEn && startDet && !stopDet |=> (state_q == osr_pkg::ST_RECV) &&
      (kind_q == osr_pkg::KIND_ADDR) && (bitCnt_q == 4'h0) && !sdaOe_q)
    else $error("start did not restart address reception");

  AST_STOP_RELEASES: assert property (
    clkEn && stopDet |=> (state_q == osr_pkg::ST_IDLE) && !sdaOe_q)
    else $error("stop did not release the bus");

  AST_ADDR_MATCH_ACK: assert property (
    seqAddrByteEnd |=> (sdaOe_q == ($past(shift_q[7:1]) == osr_pkg::SLAVE_ADDR)))
    else $error("address acknowledge does not match comparison");

  AST_ACK_HELD: assert property (
    (state_q == osr_pkg::ST_ACK) |-> sdaOe_q)
    else $error("acknowledge not held low");

  AST_NACK_RELEASE: assert property (
    seqMasterNack |=> ((state_q == osr_pkg::ST_IDLE) && !sdaOe_q) [*2])
    else $error("device kept the line after master nack");

  AST_PTR_WRAP: assert property (
    clkEn && loadSend |=> ptr_q == 8'($past(ptr_q) + 8'h01))
    else $error("pointer did not advance by one");

  AST_STATUS_CLEAR: assert property (
    clkEn && statusRead && !eventSet |=> !intPin)
    else $error("status read did not clear interrupt");

  AST_SET_WINS: assert property (
    clkEn && eventSet && !powerDown_q |=> intPin)
    else $error("interrupt event lost");

  AST_FULL_NACK: assert property (
    clkEn && !stopDet && !startDet && (state_q == osr_pkg::ST_RECV) && byteDone &&
      (kind_q == osr_pkg::KIND_DATA) && !fifoInReady |=> !sdaOe_q)
    else $error("full queue byte was acknowledged");

endmodule : osr_i2c_slave

`default_nettype wire

// file: verification/osr_i2c_master_model.sv
// Behavioural bus master that drives the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module osr_i2c_master_model (
  input  wire logic clock,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaPull
);
  // ----------------------------------------------------------------
  // Bus phases, counted in system clocks (80 ns link period)
  // ----------------------------------------------------------------
  // Idle bus rests high: clock high, data released
  initial begin
    scl     <= 1'b1;
    sdaPull <= 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One pulse; data moves mid-low, sampled mid-high away from the edges
  task automatic bitCycle(input logic b, output logic r);
    tick(2);
    sdaPull <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    @(negedge clock);
    r = sdaWire;
    tick(2);
    scl <= 1'b0;
  endtask : bitCycle

  // Also serves as repeated start when entered with the clock low
  task automatic startCond();
    tick(2);
    sdaPull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : startCond

  // Used after a refused byte too, to abandon the transfer
  task automatic stopCond();
    tick(2);
    sdaPull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b0;
    tick(4);
  endtask : stopCond

  // Eight bits MSB first, then release for the acknowledge pulse
  task automatic putByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(d[i], r);
    end
    bitCycle(1'b1, r);
    ack = !r;
  endtask : putByte

  // Receive a byte; the last wanted byte is left unacknowledged
  task automatic getByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, d[i]);
    end
    bitCycle(!more, r);
  endtask : getByte
endmodule : osr_i2c_master_model
`default_nettype wire

// file: verification/tb_osr_i2c_slave.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module tb_osr_i2c_slave;
  logic       clock, rst_b, clkEn, sampleValid, eventSet, cfgReady;
  logic [7:0] xAccelIn, yAccelIn, detectCfg;
  logic [6:0] statusIn;
  logic       scl, sdaPull, sdaOe, sdaOut, powerDown, intPin, ack;
  wire logic  sdaWire;
  int         err_total;
  int         num_checks;

  // Pull-up wins unless some party pulls low
  assign sdaWire = !(sdaPull | (sdaOe & !sdaOut));

  osr_i2c_slave uut (
    .clock       (clock),
    .rst_b       (rst_b),
    .clkEn       (clkEn),
    .sclIn       (scl),
    .sdaIn       (sdaWire),
    .sdaOut      (sdaOut),
    .sdaOe       (sdaOe),
    .xAccelIn    (xAccelIn),
    .yAccelIn    (yAccelIn),
    .statusIn    (statusIn),
    .sampleValid (sampleValid),
    .eventSet    (eventSet),
    .cfgReady    (cfgReady),
    .detectCfg   (detectCfg),
    .powerDown   (powerDown),
    .intPin      (intPin)
  );

  osr_i2c_master_model host (
    .clock   (clock),
    .sdaWire (sdaWire),
    .scl     (scl),
    .sdaPull (sdaPull)
  );

  // ----------------------------------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------------------------------
  always #5 clock = ~clock;

  task automatic test_done();
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address for writing, then load the pointer
  task automatic setPtr(input logic [7:0] ptr);
    logic a;
    host.startCond();
    host.putByte({osr_pkg::SLAVE_ADDR, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    host.putByte(ptr, a);
    chk({7'h00, a}, 8'h01);
  endtask : setPtr

  // Bytes base, base+1 ...; only the first nAck may be taken
  task automatic wrRun(input logic [7:0] ptr, input int n,
                       input logic [7:0] base, input int nAck);
    logic a;
    setPtr(ptr);
    for (int k = 0; k < n; k++) begin
      host.putByte(base + 8'(k), a);
      chk({7'h00, a}, {7'h00, k < nAck});
    end
    host.stopCond();
  endtask : wrRun

  // Expected bytes in order from the top of e
  task automatic rdRun(input logic loadPtr, input logic [7:0] ptr,
                       input int n, input logic [2:0][7:0] e);
    logic       a;
    logic [7:0] d;
    if (loadPtr) begin
      setPtr(ptr);
    end
    host.startCond();
    host.putByte({osr_pkg::SLAVE_ADDR, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    for (int k = 0; k < n; k++) begin
      host.getByte(k < n - 1, d);
      chk(d, e[2 - k]);
    end
    host.stopCond();
  endtask : rdRun

  // Bounded wait for the drained configuration
  task automatic waitCfg(input logic [7:0] exp);
    int i;
    for (i = 0; i < 50 && detectCfg !== exp; i++) begin
      @(negedge clock);
    end
    chk(detectCfg, exp);
    if (i == 50) begin
      test_done();
    end
  endtask : waitCfg

  // Hang guard
  initial begin
    #500000;
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    err_total = 0;
    num_checks = 0;
    {rst_b, sampleValid, eventSet} <= 3'h0;
    {clkEn, cfgReady} <= 2'h3;
    {xAccelIn, yAccelIn, statusIn} <= 23'h000000;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk(detectCfg, osr_pkg::DETECT_RESET);
    chk({4'h0, sdaOut, sdaOe, intPin, powerDown}, 8'h00);
    repeat (3) @(posedge clock);
    rdRun(1'b1, osr_pkg::REG_X_ACCEL, 3, 24'h000000);
    rdRun(1'b1, 8'h03, 3, 24'h000000);
    rdRun(1'b1, osr_pkg::REG_IDENT, 1, {2'b00, osr_pkg::PART_IDENT_DEFAULT, 16'h0});
    // Any one-bit slip of the address must go unanswered
    for (int i = 0; i < 7; i++) begin
      host.startCond();
      host.putByte({osr_pkg::SLAVE_ADDR ^ (7'h01 << i), 1'b0}, ack);
      chk({7'h00, ack}, 8'h00);
      host.stopCond();
    end
    @(posedge clock);
    {xAccelIn, yAccelIn, statusIn} <= {8'h80, 8'h7f, 7'h05};
    {sampleValid, eventSet} <= 2'h3;
    @(posedge clock);
    {sampleValid, eventSet} <= 2'h0;
    @(negedge clock);
    chk({7'h00, intPin}, 8'h01);
    rdRun(1'b1, osr_pkg::REG_X_ACCEL, 3, 24'h807f85);
    chk({7'h00, intPin}, 8'h00);
    wrRun(osr_pkg::REG_DETECT, 1, 8'h80, 1);
    waitCfg(8'h80);
    chk({7'h00, powerDown}, 8'h01);
    // Powered down: a new sample and an event must both be ignored
    @(posedge clock);
    {xAccelIn, sampleValid, eventSet} <= {8'h11, 2'h3};
    @(posedge clock);
    {sampleValid, eventSet} <= 2'h0;
    @(negedge clock);
    chk({7'h00, intPin}, 8'h00);
    wrRun(8'h03, 2, 8'h21, 2);
    waitCfg(8'h22);
    chk({7'h00, powerDown}, 8'h00);
    // Stalled drain: the ninth byte finds the buffer full
    @(posedge clock);
    cfgReady <= 1'b0;
    wrRun(8'h00, 9, 8'h10, 8);
    cfgReady <= 1'b1;
    waitCfg(8'h14);
    rdRun(1'b1, osr_pkg::REG_X_ACCEL, 3, 24'h807f05);
    rdRun(1'b1, 8'hff, 2, 24'h008000);
    rdRun(1'b0, 8'h00, 1, 24'h7f0000);
    test_done();
  end
endmodule : tb_osr_i2c_slave
`default_nettype wire
